// ---- pkg/adcc_pkg.sv ----
package adcc_pkg;
   localparam logic [11:0] ADCC_CTRL_OFS   = 12'h000;
   localparam logic [11:0] ADCC_SEL_OFS    = 12'h004;
   localparam logic [11:0] ADCC_RESULT_OFS = 12'h008;
   localparam logic [11:0] ADCC_INTERRUPT_CONTROL_REG_OFS   = 12'h00c;
   // control word: channel select, pending and start
   localparam int ADCC_CH_LSB    = 0;
   localparam int ADCC_START_BIT = 7;
   localparam int ADCC_PEND_BIT  = 6;
   // select word: divider and pin config
   localparam int ADCC_DIV_LSB   = 0;
   localparam int ADCC_PCR_LSB   = 4;
   // interrupt word
   localparam int ADCC_GIE_BIT   = 0;
   localparam int ADCC_CIE_BIT   = 1;
   localparam int ADCC_FLAG_BIT  = 2;
   localparam logic [3:0] ADCC_CH_RST   = 4'h0;
   localparam logic [1:0] ADCC_DIV_RST  = 2'h0;
   localparam logic [3:0] ADCC_PCR_RST  = 4'h0;
   localparam logic [3:0] ADCC_PCR_ALL  = 4'hf;
   localparam int ADCC_CONV_TAD  = 76;
   localparam int ADCC_DIV0      = 2;
   localparam int ADCC_DIV1      = 8;
   localparam int ADCC_DIV2      = 32;
   localparam int ADCC_DIV3      = 128;
   typedef enum logic [1:0] {
      ADCC_IDLE  = 2'b00,
      ADCC_HOLD  = 2'b01,
      ADCC_CONV  = 2'b10
   } adcc_state_t;
endpackage

// ---- logic/adcc_top.sv ----
module adcc_top #(
   parameter int NUM_CH = 16
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  sample_code,
   output logic      [3:0]  analog_channel_select,
   output logic             sample_reset,
   output logic             converter_power,
   output logic             converter_clk_en,
   output logic      [15:0] analog_pin_en,
   input  wire logic [15:0] port_dir_in,
   output logic      [15:0] port_dir_eff,
   input  wire logic [15:0] pull_high_opt,
   output logic      [15:0] pull_high_en,
   output logic             irq
);
   typedef struct packed {
      adcc_pkg::adcc_state_t st;
      logic [3:0]  ch;
      logic        start;
      logic        pend;
      logic [1:0]  div;
      logic [3:0]  pcr;
      logic        gie;
      logic        cie;
      logic        flag;
      logic [7:0]  result;
      logic [6:0]  divcnt;
      logic [6:0]  tadcnt;
      logic        tick;
      logic [31:0] rdata;
   } adcc_regs_t;

   adcc_regs_t r;
   adcc_regs_t next_r;

   // address decode, used only by the error response; the read mux and the write decode compare paddr themselves
   logic        hit_ctrl;
   logic        hit_sel;
   logic        hit_result;
   logic        hit_interrupt_control_reg;

   // sequencer decodes
   logic        in_conv;
   logic        last_tick;

   // converter clock divider
   logic [6:0]  div_limit;
   logic        div_wrap;

   // write data fields
   logic [3:0]  wr_ch;
   logic        wr_start;
   logic [1:0]  wr_div;
   logic [3:0]  wr_pcr;
   logic        wr_gie;
   logic        wr_cie;
   logic        wr_flag;

   // read words, formed from the current register state
   logic [31:0] rd_ctrl;
   logic [31:0] rd_sel;
   logic [31:0] rd_result;
   logic [31:0] rd_interrupt_control_reg;

   function automatic logic [6:0] adcc_ratio(input logic [1:0] code);
      unique case (code)
         2'b00: adcc_ratio = 7'(adcc_pkg::ADCC_DIV0 - 1);
         2'b01: adcc_ratio = 7'(adcc_pkg::ADCC_DIV1 - 1);
         2'b10: adcc_ratio = 7'(adcc_pkg::ADCC_DIV2 - 1);
         2'b11: adcc_ratio = 7'(adcc_pkg::ADCC_DIV3 - 1);
      endcase
   endfunction

   // pins that the pin config field turns into analog inputs
   function automatic logic [15:0] adcc_pin_mask(input logic [3:0] pcr);
      logic [15:0] m;
      m = '0;
      if (pcr == adcc_pkg::ADCC_PCR_ALL) begin
         m = 16'hffff;
      end else begin
         for (int i = 0; i < 16; i++) begin
            m[i] = (i < int'(pcr));
         end
      end
      if (NUM_CH == 6) begin
         m = m & 16'h060f;
      end
      adcc_pin_mask = m;
   endfunction

   logic        wr;
   logic        rd;
   logic        valid_addr;
   logic [15:0] amask;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign valid_addr = hit_ctrl || hit_sel || hit_result || hit_interrupt_control_reg;
   assign amask = adcc_pin_mask(r.pcr);

   assign hit_ctrl   = (paddr == adcc_pkg::ADCC_CTRL_OFS);
   assign hit_sel    = (paddr == adcc_pkg::ADCC_SEL_OFS);
   assign hit_result = (paddr == adcc_pkg::ADCC_RESULT_OFS);
   assign hit_interrupt_control_reg   = (paddr == adcc_pkg::ADCC_INTERRUPT_CONTROL_REG_OFS);

   assign in_conv   = (r.st == adcc_pkg::ADCC_CONV);
   // the last tick of a conversion; the state moves on at the next edge
   assign last_tick = in_conv && r.tick && (r.tadcnt == 7'(adcc_pkg::ADCC_CONV_TAD - 1));

   // a new divider code takes effect at once; >= keeps a shorter ratio from stalling
   assign div_limit = adcc_ratio(r.div);
   assign div_wrap  = (r.divcnt >= div_limit);

   assign wr_ch    = pwdata[adcc_pkg::ADCC_CH_LSB +: 4];
   assign wr_start = pwdata[adcc_pkg::ADCC_START_BIT];
   assign wr_div   = pwdata[adcc_pkg::ADCC_DIV_LSB +: 2];
   assign wr_pcr   = pwdata[adcc_pkg::ADCC_PCR_LSB +: 4];
   assign wr_gie   = pwdata[adcc_pkg::ADCC_GIE_BIT];
   assign wr_cie   = pwdata[adcc_pkg::ADCC_CIE_BIT];
   assign wr_flag  = pwdata[adcc_pkg::ADCC_FLAG_BIT];

   // unused bits read as zero
   assign rd_ctrl   = {24'h0, r.start, r.pend, 2'b00, r.ch};
   assign rd_sel    = {24'h0, r.pcr, 2'b00, r.div};
   assign rd_result = {24'h0, r.result};
   assign rd_interrupt_control_reg   = {29'h0, r.flag, r.cie, r.gie};

   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      // converter clock enable from the system clock divider
      if (div_wrap) begin
         next_r.divcnt = 7'h00;
         next_r.tick = 1'b1;
      end else begin
         next_r.divcnt = r.divcnt + 7'h01;
      end
      // read data is captured in setup so the access phase answers at once
      if (rd) begin
         unique case (paddr)
            adcc_pkg::ADCC_CTRL_OFS:
               next_r.rdata = rd_ctrl;
            adcc_pkg::ADCC_SEL_OFS:
               next_r.rdata = rd_sel;
            adcc_pkg::ADCC_RESULT_OFS:
               next_r.rdata = rd_result;
            adcc_pkg::ADCC_INTERRUPT_CONTROL_REG_OFS:
               next_r.rdata = rd_interrupt_control_reg;
            default:
               next_r.rdata = 32'h0;
         endcase
      end
      if (wr) begin
         unique case (paddr)
            adcc_pkg::ADCC_CTRL_OFS: begin
               next_r.ch = wr_ch;
               next_r.start = wr_start;
            end
            adcc_pkg::ADCC_SEL_OFS: begin
               next_r.div = wr_div;
               next_r.pcr = wr_pcr;
            end
            adcc_pkg::ADCC_INTERRUPT_CONTROL_REG_OFS: begin
               next_r.gie = wr_gie;
               next_r.cie = wr_cie;
               // writing zero clears the request flag; a set in the same cycle still wins
               if (!wr_flag) begin
                  next_r.flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      unique case (r.st)
         adcc_pkg::ADCC_IDLE: begin
            if (r.start) begin
               next_r.st = adcc_pkg::ADCC_HOLD;
               next_r.pend = 1'b1;
            end
         end
         adcc_pkg::ADCC_HOLD: begin
            next_r.pend = 1'b1;
            if (!r.start) begin
               next_r.st = adcc_pkg::ADCC_CONV;
               next_r.tadcnt = 7'h00;
            end
         end
         adcc_pkg::ADCC_CONV: begin
            if (r.start) begin
               next_r.st = adcc_pkg::ADCC_HOLD;
            end else if (r.tick) begin
               if (last_tick) begin
                  next_r.st = adcc_pkg::ADCC_IDLE;
                  next_r.pend = 1'b0;
                  next_r.result = sample_code;
                  next_r.flag = 1'b1;
               end else begin
                  next_r.tadcnt = r.tadcnt + 7'h01;
               end
            end
         end
         default: begin
            next_r.st = adcc_pkg::ADCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st:     adcc_pkg::ADCC_IDLE,
                ch:     adcc_pkg::ADCC_CH_RST,
                start:  1'b0,
                pend:   1'b0,
                div:    adcc_pkg::ADCC_DIV_RST,
                pcr:    adcc_pkg::ADCC_PCR_RST,
                gie:    1'b0,
                cie:    1'b0,
                flag:   1'b0,
                result: 8'h00,
                divcnt: 7'h00,
                tadcnt: 7'h00,
                tick:   1'b0,
                rdata:  32'h0};
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !valid_addr;
   assign analog_channel_select = r.ch;
   assign sample_reset = !in_conv;
   assign converter_power = (r.pcr != 4'h0);
   assign converter_clk_en = r.tick && in_conv;
   assign analog_pin_en = amask;
   assign port_dir_eff = port_dir_in | amask;
   assign pull_high_en = pull_high_opt & ~amask;
   assign irq = r.flag && r.cie && r.gie;
endmodule // adcc_top

// ---- verif/adcc_sva.sv ----
module adcc_sva #(
   parameter int NUM_CH = 16
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [3:0]  analog_channel_select,
   input wire logic        sample_reset,
   input wire logic        converter_power,
   input wire logic        converter_clk_en,
   input wire logic [15:0] analog_pin_en,
   input wire logic [15:0] port_dir_in,
   input wire logic [15:0] port_dir_eff,
   input wire logic [15:0] pull_high_opt,
   input wire logic [15:0] pull_high_en,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] ticks;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ticks <= 8'h0;
      else if (sample_reset)
         ticks <= 8'h0;
      else if (converter_clk_en)
         ticks <= ticks + 8'h1;
   end
   a_pull_drop: assert property (pull_high_en == (pull_high_opt & ~analog_pin_en))
      else $error("pull-high on analog pin");
   a_dir_over: assert property (port_dir_eff == (port_dir_in | analog_pin_en))
      else $error("direction not overridden");
   a_power_off: assert property (converter_power == (analog_pin_en != 16'h0))
      else $error("power and pins disagree");
   a_pins_low: assert property (NUM_CH != 16 || ((analog_pin_en + 16'h1) & analog_pin_en) == 16'h0)
      else $error("analog pins not contiguous");
   a_tick_idle: assert property (sample_reset |-> !converter_clk_en)
      else $error("tick while held");
   a_tick_gap: assert property (converter_clk_en |=> !converter_clk_en)
      else $error("ticks too close");
   a_conv_len: assert property (ticks <= 8'h4c)
      else $error("conversion overran");
   a_chan_write: assert property ($changed(analog_channel_select) |-> $past(psel && penable && pwrite && paddr == 12'h000))
      else $error("channel changed unasked");
   a_irq_cause: assert property ($rose(irq) |-> $past(psel && pwrite && paddr == 12'h00c) || !$past(sample_reset) || !$past(sample_reset, 2))
      else $error("irq without cause");
endmodule // adcc_sva

bind adcc_top adcc_sva #(.NUM_CH(NUM_CH)) u_adcc_sva (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .analog_channel_select, .sample_reset, .converter_power, .converter_clk_en, .analog_pin_en,
   .port_dir_in, .port_dir_eff, .pull_high_opt, .pull_high_en, .irq);

// ---- verif/adcc_src.sv ----
module adcc_src (
   input wire logic [3:0] analog_channel_select,
   output logic     [7:0] sample_code
);
   timeunit 1ns;
   timeprecision 1ns;
   // channel 7 sits at full scale, the rest carry their number so misrouting shows
   assign sample_code = (analog_channel_select == 4'h7) ? 8'hff : {4'ha, analog_channel_select};
endmodule // adcc_src

// ---- verif/adcc_top_tb.sv ----
module adcc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv_err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd_d;
   logic        pready, pslverr, sample_reset, converter_power, converter_clk_en, irq;
   logic [7:0]  sample_code;
   logic [3:0]  ch_sel;
   logic [15:0] pin_en, pin_en6, dir_eff, pull_en, dir_in = 16'h5a5a, pull_opt = 16'hf0ff;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0;
   always #50 clk = ~clk;
   adcc_top u_adcc_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sample_code, .analog_channel_select(ch_sel), .sample_reset, .converter_power,
      .converter_clk_en, .analog_pin_en(pin_en), .port_dir_in(dir_in), .port_dir_eff(dir_eff),
      .pull_high_opt(pull_opt), .pull_high_en(pull_en), .irq);
   adcc_top #(.NUM_CH(6)) u_adcc_top_six (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata(), .pready(), .pslverr(), .sample_code, .analog_channel_select(), .sample_reset(),
      .converter_power(), .converter_clk_en(), .analog_pin_en(pin_en6), .port_dir_in(dir_in),
      .port_dir_eff(), .pull_high_opt(pull_opt), .pull_high_en(), .irq());
   adcc_src u_adcc_src (.analog_channel_select(ch_sel), .sample_code);
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_d = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_pins;
      logic [15:0] m;
      for (int n = 0; n < 16; n++) begin
         m = (n == 15) ? 16'hffff : 16'((1 << n) - 1);
         xfer(1'b1, 12'h004, 32'(n << 4) | 32'h1);
         @(negedge clk);
         chk("pins", m, pin_en);
         chk("pins six", m & 16'h060f, pin_en6);
         chk("power", {15'h0, n != 0}, {15'h0, converter_power});
         chk("pull", pull_opt & ~m, pull_en);
         chk("dir", dir_in | m, dir_eff);
      end
   endtask
   task automatic t_conv(logic [1:0] dv, logic [3:0] ch, logic ie);
      int t, r, k;
      r = (dv == 2'h1) ? 8 : (dv == 2'h2) ? 32 : 128;
      xfer(1'b1, 12'h004, {24'h0, 4'hf, 2'h0, dv});
      xfer(1'b1, 12'h00c, {30'h0, ie, ie});
      xfer(1'b1, 12'h000, {24'h0, 4'h0, ch});
      xfer(1'b1, 12'h000, {24'h0, 4'h8, ch});
      xfer(1'b0, 12'h000, 32'h0);
      chk("held", {8'h0, 4'hc, ch}, rd_d[15:0]);
      chk("hold reset", 16'h1, {15'h0, sample_reset});
      xfer(1'b1, 12'h000, {24'h0, 4'h0, ch});
      t = 0;
      while (sample_reset === 1'b1 && t < 300) begin
         @(negedge clk);
         t++;
      end
      k = 0;
      while (sample_reset !== 1'b1 && t < 12000) begin
         if (converter_clk_en === 1'b1)
            k++;
         @(negedge clk);
         t++;
      end
      chk("span", 16'h1, {15'h0, t >= 75 * r && t <= 76 * r + 2});
      chk("ticks", 16'h004c, 16'(k));
      xfer(1'b0, 12'h000, 32'h0);
      chk("pending", {12'h0, ch}, rd_d[15:0]);
      xfer(1'b0, 12'h008, 32'h0);
      chk("result", (ch == 4'h7) ? 16'hff : {8'h0, 4'ha, ch}, rd_d[15:0]);
      chk("irq", {15'h0, ie}, {15'h0, irq});
      xfer(1'b0, 12'h00c, 32'h0);
      chk("flag", 16'h1, {15'h0, rd_d[2]});
      xfer(1'b1, 12'h00c, {30'h0, ie, ie});
      @(negedge clk);
      chk("irq clear", 16'h0, {15'h0, irq});
   endtask
   task automatic t_unmapped;
      xfer(1'b0, 12'h010, 32'h0);
      chk("error", 16'h1, {15'h0, slv_err});
      chk("unmapped", 16'h0, rd_d[15:0]);
   endtask
   task automatic print_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_pins;
      // divider 00 stays unused: at this system clock it would break the minimum period
      for (int d = 1; d < 4; d++)
         t_conv(2'(d), 4'(4 + d), d != 2);
      t_unmapped;
      print_verdict;
   end
endmodule // adcc_top_tb
